// File: shared/dpba_defs.vh
// register map, field positions and reset values of the dma progress and byte aligner
`ifndef DPBA_DEFS_VH
`define DPBA_DEFS_VH

`define DPBA_OFF_MEM_START   8'h00
`define DPBA_OFF_PCI_START   8'h04
`define DPBA_OFF_WORD_COUNT  8'h08
`define DPBA_OFF_CONTROL     8'h0C
`define DPBA_OFF_STATUS      8'h10
`define DPBA_OFF_WORDS_LEFT  8'h64
`define DPBA_OFF_LIVE_MEM    8'h68
`define DPBA_OFF_LIVE_PCI    8'h6C

`define DPBA_CTL_GO          0
`define DPBA_CTL_DIR         1
`define DPBA_CTL_INT_EN      2
`define DPBA_CTL_NMI_REQ     3

`define DPBA_STS_BUSY        0
`define DPBA_STS_DONE        1

`define DPBA_RST_WORD        32'h00000000
`define DPBA_FIFO_DEPTH      32
`define DPBA_FIFO_AW         5

`endif

// File: core/dpba_fifo.v
// synchronous valid/ready fifo for aligned destination words
module dpba_fifo #(
    parameter W  = 36,
    parameter D  = 32,
    parameter AW = 5
) (
    // clock and reset
    input  wire          clk,
    input  wire          rst_n,
    // fill side
    input  wire          in_valid,
    input  wire [W-1:0]  in_data,
    output wire          in_ready,
    // drain side
    output wire          out_valid,
    output wire [W-1:0]  out_data,
    input  wire          out_ready
);
    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0]   count_r;
    wire         push;
    wire         pop;

    assign in_ready  = (count_r != D[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// File: core/dpba_core.v
// dma progress status registers and byte aligner with apb register access
`include "dpba_defs.vh"

module dpba_core (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // source byte stream
    input  wire        src_valid,
    input  wire [31:0] src_data,
    output reg         src_ready,
    // destination word stream
    output reg         dst_valid,
    output reg  [31:0] dst_data,
    output reg  [3:0]  dst_be,
    input  wire        dst_ready,
    // transfer state
    output reg         xfer_busy,
    output reg         xfer_to_mem,
    // cpu requests, active low
    output reg         cpu_int_n,
    output reg         cpu_nmi_n
);
    // bytes a word step may move from a lane, capped by what is left
    function [2:0] take;
        input [33:0] left;
        input [1:0]  lane;
        reg   [2:0]  room;
        begin
            room = 3'h4 - {1'b0, lane};
            if (left < {31'h0, room}) begin
                take = left[2:0];
            end else begin
                take = room;
            end
        end
    endfunction

    function [3:0] be_mask;
        input [2:0] n;
        input [1:0] lane;
        reg   [7:0] m;
        begin
            m = ((8'h01 << n) - 8'h01) << lane;
            be_mask = m[3:0];
        end
    endfunction

    reg  [31:0] mem_start_r;
    reg  [31:0] pci_start_r;
    reg  [31:0] word_count_r;
    reg         dir_r;
    reg         int_en_r;
    reg         nmi_req_r;
    reg         busy_r;
    reg         done_r;
    reg  [31:0] words_left_count;
    reg  [31:0] live_transfer_pointer;
    reg  [31:0] live_pci_r;
    reg  [33:0] in_left_r;
    reg  [33:0] out_left_r;
    reg  [1:0]  src_lane_r;
    reg  [1:0]  dst_lane_r;
    reg  [3:0]  fill_r;
    reg  [63:0] hold_r;

    reg  [2:0]  in_take;
    reg  [2:0]  need;
    reg         accept;
    reg         emit;
    reg  [3:0]  fill_a;
    reg  [63:0] hold_a;
    reg  [63:0] src_bytes;
    reg  [63:0] hold_nxt;
    reg  [3:0]  fill_nxt;
    reg  [33:0] in_left_nxt;
    reg  [33:0] out_left_nxt;
    reg  [33:0] words_up;
    reg  [31:0] word_out;
    reg  [31:0] rd_val;
    reg         rd_hit;

    wire        apb_wr;
    wire        go;
    wire        done_clr;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [35:0] fifo_out_data;
    wire        fifo_pop_ready;

    assign apb_wr   = psel & penable & pready & pwrite;
    assign go       = apb_wr & (paddr == `DPBA_OFF_CONTROL) & pwdata[`DPBA_CTL_GO] & ~busy_r;
    assign done_clr = apb_wr & (paddr == `DPBA_OFF_STATUS) & pwdata[`DPBA_STS_DONE];
    assign fifo_pop_ready = ~dst_valid | dst_ready;

    // aligner step: drain a destination word, then append a source word
    always @* begin
        in_take   = take(in_left_r, src_lane_r);
        need      = take(out_left_r, dst_lane_r);
        accept    = src_valid & src_ready;
        emit      = busy_r & (out_left_r != 34'h0) & fifo_in_ready
                    & (fill_r >= {1'b0, need});
        word_out  = hold_r[31:0] << {dst_lane_r, 3'b000};
        fill_a    = emit ? fill_r - {1'b0, need} : fill_r;
        hold_a    = emit ? hold_r >> {need, 3'b000} : hold_r;
        src_bytes = ({32'h00000000, src_data} >> {src_lane_r, 3'b000})
                    & ((64'h0000000000000001 << {in_take, 3'b000}) - 64'h1);
        hold_nxt  = accept ? (hold_a | (src_bytes << {fill_a[2:0], 3'b000})) : hold_a;
        fill_nxt  = accept ? fill_a + {1'b0, in_take} : fill_a;
        in_left_nxt  = accept ? in_left_r - {31'h0, in_take} : in_left_r;
        out_left_nxt = emit ? out_left_r - {31'h0, need} : out_left_r;
        words_up     = (out_left_nxt + 34'h3) >> 2;
    end

    // register read decode
    always @* begin
        rd_hit = 1'b1;
        case (paddr)
            `DPBA_OFF_MEM_START:  rd_val = mem_start_r;
            `DPBA_OFF_PCI_START:  rd_val = pci_start_r;
            `DPBA_OFF_WORD_COUNT: rd_val = word_count_r;
            `DPBA_OFF_CONTROL:    rd_val = {28'h0, nmi_req_r, int_en_r, dir_r, 1'b0};
            `DPBA_OFF_STATUS:     rd_val = {30'h0, done_r, busy_r};
            `DPBA_OFF_WORDS_LEFT: rd_val = words_left_count;
            `DPBA_OFF_LIVE_MEM:   rd_val = live_transfer_pointer;
            `DPBA_OFF_LIVE_PCI:   rd_val = live_pci_r;
            default: begin
                rd_val = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // apb: one wait-free access, answer registered in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel & ~penable) begin
                prdata  <= pwrite ? 32'h00000000 : rd_val;
                pslverr <= ~rd_hit | (pwrite & (paddr[7:4] == 4'h6));
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // software-written configuration
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_start_r  <= `DPBA_RST_WORD;
            pci_start_r  <= `DPBA_RST_WORD;
            word_count_r <= `DPBA_RST_WORD;
            dir_r        <= 1'b0;
            int_en_r     <= 1'b0;
            nmi_req_r    <= 1'b0;
        end else if (apb_wr) begin
            if ((paddr == `DPBA_OFF_MEM_START) && !busy_r) begin
                mem_start_r <= pwdata;
            end
            if ((paddr == `DPBA_OFF_PCI_START) && !busy_r) begin
                pci_start_r <= pwdata;
            end
            if ((paddr == `DPBA_OFF_WORD_COUNT) && !busy_r) begin
                word_count_r <= pwdata;
            end
            if (paddr == `DPBA_OFF_CONTROL) begin
                if (!busy_r) begin
                    dir_r <= pwdata[`DPBA_CTL_DIR];
                end
                int_en_r  <= pwdata[`DPBA_CTL_INT_EN];
                nmi_req_r <= pwdata[`DPBA_CTL_NMI_REQ];
            end
        end
    end

    // transfer progress and aligner state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r                <= 1'b0;
            done_r                <= 1'b0;
            words_left_count      <= `DPBA_RST_WORD;
            live_transfer_pointer <= `DPBA_RST_WORD;
            live_pci_r            <= `DPBA_RST_WORD;
            in_left_r             <= 34'h0;
            out_left_r            <= 34'h0;
            src_lane_r            <= 2'b00;
            dst_lane_r            <= 2'b00;
            fill_r                <= 4'h0;
            hold_r                <= 64'h0;
            src_ready             <= 1'b0;
        end else if (go) begin
            busy_r                <= (word_count_r != 32'h0);
            words_left_count      <= word_count_r;
            live_transfer_pointer <= mem_start_r;
            live_pci_r            <= pci_start_r;
            in_left_r             <= {word_count_r, 2'b00};
            out_left_r            <= {word_count_r, 2'b00};
            // direction arrives with the same write as go, not yet in dir_r
            src_lane_r            <= pwdata[`DPBA_CTL_DIR] ? pci_start_r[1:0] : mem_start_r[1:0];
            dst_lane_r            <= pwdata[`DPBA_CTL_DIR] ? mem_start_r[1:0] : pci_start_r[1:0];
            fill_r                <= 4'h0;
            hold_r                <= 64'h0;
            src_ready             <= (word_count_r != 32'h0);
            if (done_clr) begin
                done_r <= 1'b0;
            end
        end else begin
            hold_r           <= hold_nxt;
            fill_r           <= fill_nxt;
            in_left_r        <= in_left_nxt;
            out_left_r       <= out_left_nxt;
            words_left_count <= words_up[31:0];
            if (accept) begin
                src_lane_r <= 2'b00;
            end
            if (emit) begin
                dst_lane_r <= dst_lane_r + need[1:0];
            end
            // source side address moves on accept, destination side on emit
            if (dir_r) begin
                if (accept) begin
                    live_pci_r <= live_pci_r + {29'h0, in_take};
                end
                if (emit) begin
                    live_transfer_pointer <= live_transfer_pointer + {29'h0, need};
                end
            end else begin
                if (accept) begin
                    live_transfer_pointer <= live_transfer_pointer + {29'h0, in_take};
                end
                if (emit) begin
                    live_pci_r <= live_pci_r + {29'h0, need};
                end
            end
            src_ready <= busy_r & (in_left_nxt != 34'h0) & (fill_nxt <= 4'h4);
            if (busy_r && (out_left_nxt == 34'h0)) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end else if (done_clr) begin
                done_r <= 1'b0;
            end
        end
    end

    dpba_fifo #(
        .W  (36),
        .D  (`DPBA_FIFO_DEPTH),
        .AW (`DPBA_FIFO_AW)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (emit),
        .in_data   ({be_mask(need, dst_lane_r), word_out}),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (fifo_pop_ready)
    );

    // registered output stage and cpu request pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_valid   <= 1'b0;
            dst_data    <= 32'h00000000;
            dst_be      <= 4'h0;
            xfer_busy   <= 1'b0;
            xfer_to_mem <= 1'b0;
            cpu_int_n   <= 1'b1;
            cpu_nmi_n   <= 1'b1;
        end else begin
            if (fifo_pop_ready) begin
                dst_valid <= fifo_out_valid;
                dst_data  <= fifo_out_data[31:0];
                dst_be    <= fifo_out_data[35:32];
            end
            xfer_busy   <= busy_r;
            xfer_to_mem <= dir_r;
            cpu_int_n   <= ~(done_r & int_en_r);
            cpu_nmi_n   <= ~nmi_req_r;
        end
    end
endmodule

// File: testbench/dpba_chk.sv
// port assertions for the dma progress and byte aligner
module dpba_chk (
    // apb
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // destination stream and cpu requests
    input logic        dst_valid,
    input logic [31:0] dst_data,
    input logic [3:0]  dst_be,
    input logic        dst_ready,
    input logic        cpu_int_n,
    input logic        cpu_nmi_n
);
    timeunit 1ns;
    timeprecision 1ps;
    wire ro_hit = paddr == 8'h64 || paddr == 8'h68 || paddr == 8'h6C;
    wire mapped = ro_hit || paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence ctl_wr_s;
        psel && penable && pready && pwrite && paddr == 8'h0C;
    endsequence
    a_pready_answer:
        assert property (setup_s |=> pready) else $error("no ready after setup");
    a_pready_single:
        assert property (pready |=> !pready) else $error("ready held too long");
    a_ro_write_err:
        assert property (setup_s ##0 (pwrite && ro_hit) |=> pslverr)
        else $error("read-only write not refused");
    a_unmapped_zero:
        assert property (setup_s ##0 (!pwrite && !mapped) |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_dst_hold:
        assert property (dst_valid && !dst_ready |=> dst_valid && $stable(dst_data)
            && $stable(dst_be)) else $error("destination word changed before taken");
    a_be_contig:
        assert property (dst_valid |-> dst_be inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7,
            4'h8, 4'hC, 4'hE, 4'hF}) else $error("byte lanes not contiguous");
    a_nmi_raise:
        assert property (ctl_wr_s ##0 pwdata[3] |-> ##[1:2] !cpu_nmi_n)
        else $error("nonmaskable request missing");
    a_int_mask:
        assert property (ctl_wr_s ##0 !pwdata[2] |-> ##[1:2] cpu_int_n)
        else $error("masked request still shown");
endmodule

bind dpba_core dpba_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dst_valid(dst_valid),
    .dst_data(dst_data), .dst_be(dst_be), .dst_ready(dst_ready),
    .cpu_int_n(cpu_int_n), .cpu_nmi_n(cpu_nmi_n));

// File: testbench/dpba_far.sv
// far-side model: byte source and checking word sink
module dpba_far (
    // control from the bench
    input  logic        clk,
    input  logic        load,
    input  logic        hold,
    input  logic [1:0]  soff,
    input  logic [1:0]  doff,
    input  logic [31:0] total,
    // source side
    input  logic        src_ready,
    output logic        src_valid,
    output logic [31:0] src_data,
    // sink side
    input  logic        dst_valid,
    input  logic [31:0] dst_data,
    input  logic [3:0]  dst_be,
    output logic        dst_ready,
    output int          got,
    output int          bad
);
    timeunit 1ns;
    timeprecision 1ps;
    int          si;
    int          tick;
    logic [31:0] sd, pd, ed, m;
    logic [3:0]  sb, eb;
    // word w of a stream starting at lane off; lanes outside carry filler
    function automatic void word(input int w, input logic [1:0] off, output logic [31:0] d,
                                 output logic [3:0] b);
        int idx;
        for (int l = 0; l < 4; l++) begin
            idx = 4 * w + l - int'(off);
            b[l] = idx >= 0 && idx < int'(total);
            d[8*l +: 8] = b[l] ? 8'(8'h10 + idx) : 8'(8'hA5 ^ w);
        end
    endfunction
    initial dst_ready = 1'b0;
    assign src_valid = si < (int'(soff) + int'(total) + 3) / 4;
    always_comb begin
        word(si - 1, soff, pd, sb);
        word(si, soff, sd, sb);
        src_data = src_valid ? sd : ~pd;
        word(got, doff, ed, eb);
        m = {{8{eb[3]}}, {8{eb[2]}}, {8{eb[1]}}, {8{eb[0]}}};
    end
    always @(posedge clk) begin
        tick <= tick + 1;
        dst_ready <= !hold && tick % 3 != 0;
        if (load) begin
            si <= 0;
            got <= 0;
            bad <= 0;
        end else begin
            if (src_valid && src_ready)
                si <= si + 1;
            if (dst_valid && dst_ready) begin
                got <= got + 1;
                if (dst_be !== eb || (dst_data & m) !== (ed & m))
                    bad <= bad + 1;
            end
        end
    end
endmodule

// File: testbench/testbench.sv
// self-checking bench for the dma progress and byte aligner
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        load = 1'b1;
    logic        hold = 1'b0;
    logic [1:0]  soff = 2'h0;
    logic [1:0]  doff = 2'h0;
    logic [31:0] total = 32'h0;
    logic [31:0] rd;
    logic        err;
    wire  [31:0] prdata, src_data, dst_data;
    wire  [3:0]  dst_be;
    wire         pready, pslverr, src_valid, src_ready, dst_valid, dst_ready;
    wire         xfer_busy, xfer_to_mem, cpu_int_n, cpu_nmi_n;
    int          got, bad;
    int          num_errors = 0;
    int          n_tests = 0;

    always #2 pclk = ~pclk;

    dpba_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_valid(src_valid), .src_data(src_data),
        .src_ready(src_ready), .dst_valid(dst_valid), .dst_data(dst_data),
        .dst_be(dst_be), .dst_ready(dst_ready), .xfer_busy(xfer_busy),
        .xfer_to_mem(xfer_to_mem), .cpu_int_n(cpu_int_n), .cpu_nmi_n(cpu_nmi_n));
    dpba_far u_far (.clk(pclk), .load(load), .hold(hold), .soff(soff), .doff(doff),
        .total(total), .src_ready(src_ready), .src_valid(src_valid),
        .src_data(src_data), .dst_valid(dst_valid), .dst_data(dst_data),
        .dst_be(dst_be), .dst_ready(dst_ready), .got(got), .bad(bad));

    task stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ctl: bit0 start, bit1 pci to memory, bit2 interrupt enable
    task xfer(input logic [31:0] ms, input logic [31:0] ps, input int n, input logic [3:0] ctl);
        soff <= ctl[1] ? ps[1:0] : ms[1:0];
        doff <= ctl[1] ? ms[1:0] : ps[1:0];
        total <= 32'(4 * n);
        load <= 1'b1;
        apb(1'b1, 8'h00, ms);
        load <= 1'b0;
        apb(1'b1, 8'h04, ps);
        apb(1'b1, 8'h08, 32'(n));
        apb(1'b1, 8'h0C, {28'h0, ctl});
    endtask

    task fin(input logic [31:0] ms, input logic [31:0] ps, input int n);
        while (got < (doff + 4 * n + 3) / 4) @(posedge pclk);
        chk(bad, 0);
        chk(got, (doff + 4 * n + 3) / 4);
        apb(1'b0, 8'h64, 32'h0);
        chk(rd, 0);
        apb(1'b0, 8'h68, 32'h0);
        chk(rd, ms + 4 * n);
        apb(1'b0, 8'h6C, 32'h0);
        chk(rd, ps + 4 * n);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd[0], 0);
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(8'h64 + 4 * i), 32'h0);
            chk(rd, 0);
        end
        apb(1'b1, 8'h64, 32'h5);
        chk(err, 1);
        apb(1'b0, 8'h64, 32'h0);
        chk(rd, 0);
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[30:0], err}, 1);
        $display("status register test done");
        xfer(32'h102, 32'h203, 3, 4'h1);
        fin(32'h102, 32'h203, 3);
        $display("memory to pci test done");
        xfer(32'h403, 32'h302, 5, 4'h3);
        repeat (2) @(posedge pclk);
        chk(xfer_to_mem, 1);
        fin(32'h403, 32'h302, 5);
        $display("pci to memory test done");
        hold <= 1'b1;
        xfer(32'h1000, 32'h2001, 40, 4'h5);
        repeat (150) @(posedge pclk);
        chk(src_ready, 0);
        chk(xfer_busy, 1);
        apb(1'b1, 8'h00, 32'h5555);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h1000);
        apb(1'b0, 8'h64, 32'h0);
        chk(rd != 0, 1);
        hold <= 1'b0;
        fin(32'h1000, 32'h2001, 40);
        chk(cpu_int_n, 0);
        apb(1'b1, 8'h10, 32'h2);
        repeat (2) @(posedge pclk);
        chk(cpu_int_n, 1);
        apb(1'b1, 8'h0C, 32'h8);
        repeat (2) @(posedge pclk);
        chk(cpu_nmi_n, 0);
        $display("full buffer and request test done");
        stop_test();
    end

    initial begin
        #80000;
        num_errors++;
        stop_test();
    end
endmodule
